// >>> pxb_bridge_dev.sv
// Notes on behaviour
// R1: board holds both mode selects low, stable
// R2: second mode select low: sample request straps
// R3: zero straps: clock power management, two devices
// R4: straps latched once, held until next reset
// R5: class code reports bridge, PCI-to-PCI subclass
// R6: programming interface 00h none, 01h subtractive; code picks 01h from the legacy bit, not from subtractive enable
// R7: legacy bit forwards all memory, I/O
// R8: type-1 configuration still checks bus range
// R9: legacy hides PCI-X/PCIe capabilities, reads zero
// R10: subtractive enable claims PCI cycles outside window
// R11: config reachable by link config requests
// R12: upstream root complex, downstream PCI devices
// R13: format bits give header size, data
// R14: payload one to sixty-four doublewords
// R15: address, ID or implicit routing by type
// R16: message destination from type low bits
// R17: baseline messages use traffic class zero
// R18: advanced-switching messages not implemented
// R19: virtual isochronous off at reset, bit 26
// R20: control bits choose upstream traffic class 1-7
// R21: nonzero class cfg/io/message is malformed
// R22: memory packets always converted regardless isochronous
// R23: capability version 1h in version field
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module pxb_bridge_dev
	import pxb_pkg::*;
#(
	parameter logic [15:0] VENDOR_ID      = 16'h0abc,
	parameter logic [15:0] DEVICE_ID      = 16'h0123,
	parameter logic [7:0]  REVISION_ID    = 8'h00,
	parameter int          MAX_PAYLOAD_DW = PAYLOAD_MAX_DW
)(
	input  wire logic        clk,
	input  wire logic        rst,
	pxb_if.dev               link,
	input  wire logic [1:0]  reqStrapPins,
	input  wire logic        pciCycValid,
	input  wire logic [31:0] pciCycAddr,
	output logic             clkPmEnable,
	output logic             twoDeviceLimit,
	output logic             legacyMode,
	output logic             viEnable,
	output logic [2:0]       upstreamTc,
	output logic             dnForward,
	output logic             dnMalformed,
	output logic             pciClaim
);
	// identity values above are arbitrary
	if (MAX_PAYLOAD_DW < 1 || MAX_PAYLOAD_DW > 1023)
	begin : gBadPayload
		$error("MAX_PAYLOAD_DW out of range");
	end
	localparam logic [LEN_W-1:0] MAX_LEN = LEN_W'(MAX_PAYLOAD_DW);
	typedef struct packed {
		logic [3:0]       sync1;
		logic [3:0]       sync2;
		pxb_life_t        life;
		logic [1:0]       strapVal;
		logic             clkPm;
		logic             legacy;
		logic             subDec;
		logic             viEn;
		logic [2:0]       upTc;
		logic [11:0]      memBase;
		logic [11:0]      memLimit;
		logic [7:0]       priBus;
		logic [7:0]       secBus;
		logic [7:0]       subBus;
		logic [15:0]      pcixHi;
		logic [31:0]      cfgRdata;
		logic             cfgRvalid;
		logic             respValid;
		logic             respFwd;
		logic             respMal;
		logic [1:0]       respRoute;
		logic [2:0]       respDest;
		logic             respHdr4;
		logic             respData;
		logic             dnFwd;
		logic             dnMal;
		logic             claim;
	} pxb_dev_state_t;

	localparam pxb_dev_state_t DEV_INIT =
		'{life: LIFE_HELD, upTc: UPTC_RESET, memBase: 12'hfff, default: '0};
	pxb_dev_state_t s;
	pxb_dev_state_t next_s;
	logic       perstN;
	logic       modeOne;
	logic [1:0] strapNow;
	assign perstN   = s.sync2[3];
	assign modeOne  = s.sync2[2];
	assign strapNow = s.sync2[1:0];
	always_comb
	begin
		logic [31:0] rd;
		logic        hasData;
		logic        isMem;
		logic        isIo;
		logic        isCfg0;
		logic        isCfg1;
		logic        isMsg;
		logic        isAs;
		logic        lenOk;
		logic        tcBad;
		logic        bad;
		logic        inWin;
		logic        fwd;
		pxb_route_t  route;
		rd = '0;
		fwd = 1'b0;
		next_s = s;
		next_s.sync1 = {link.fundamentalResetN, link.modeSelectOne, reqStrapPins};
		next_s.sync2 = s.sync1;
		next_s.cfgRvalid = 1'b0;
		next_s.respValid = 1'b0;
		next_s.dnFwd = 1'b0;
		next_s.dnMal = 1'b0;
		next_s.claim = 1'b0;
		hasData = link.tlpFmt[FMT_DATA_BIT]; // R13
		isMem   = link.tlpType[4:1] == TYPE_MEM[4:1];
		isIo    = link.tlpType == TYPE_IO;
		isCfg0  = link.tlpType == TYPE_CFG0;
		isCfg1  = link.tlpType == TYPE_CFG1;
		isMsg   = link.tlpType[4:3] == MSG_GRP;
		isAs    = link.tlpType[4:3] == AS_GRP; // R18
		if (isMem || isIo) // R15
			route = ROUTE_ADDR;
		else if (isCfg0 || isCfg1)
			route = ROUTE_ID;
		else if (isMsg)
			route = ROUTE_IMPL;
		else
			route = ROUTE_NONE;
		lenOk = !hasData || (link.tlpLen != '0 && link.tlpLen <= MAX_LEN); // R14
		tcBad = !isMem && link.tlpTc != TC_ZERO; // R21 R17
		bad   = !lenOk || tcBad || isAs || route == ROUTE_NONE;
		inWin = link.tlpAddr[31:20] >= s.memBase && link.tlpAddr[31:20] <= s.memLimit;
		if (isMem)
			fwd = s.legacy || inWin; // R7 R22
		else if (isIo)
			fwd = s.legacy; // R7
		else if (isCfg1)
			fwd = link.tlpBus >= s.secBus && link.tlpBus <= s.subBus; // R8
		else
			fwd = 1'b0;
		fwd = fwd && !bad;
		unique case (link.cfgAddr)
			OFF_IDS: rd = {DEVICE_ID, VENDOR_ID};
			OFF_CLASS:
				rd = {BASE_CLASS, SUB_CLASS, s.legacy ? PROGIF_SUB : PROGIF_NOSUB, REVISION_ID}; // R5 R6
			OFF_BUSNUM: rd = {8'h00, s.subBus, s.secBus, s.priBus};
			OFF_MEMWIN: rd = {s.memLimit, 4'h0, s.memBase, 4'h0};
			OFF_CAPPTR: rd = s.legacy ? 32'h0 : {24'h0, OFF_PCIX}; // R9
			OFF_PREFETCH:
			begin
				rd[VI_EN_BIT] = s.viEn;
				rd[UPTC_LSB +: 3] = s.upTc;
			end
			OFF_PCIX: rd = s.legacy ? 32'h0 : {s.pcixHi, OFF_PCIECAP, CAP_ID_PCIX}; // R9
			OFF_PCIECAP:
				rd = s.legacy ? 32'h0 : {12'h0, CAP_VER, 8'h00, CAP_ID_PCIE}; // R23 R9
			OFF_LEGACY:
			begin
				rd[LEGACY_BIT] = s.legacy;
				rd[SUBDEC_BIT] = s.subDec;
			end
			OFF_STRAPST: rd = {29'h0, s.clkPm, s.strapVal};
			default: rd = '0;
		endcase
		unique case (s.life)
			LIFE_HELD:
				if (perstN)
				begin
					next_s.life = LIFE_RUN;
					if (!modeOne) // R2
					begin
						next_s.strapVal = strapNow; // R4
						next_s.clkPm = strapNow == STRAP_CLKPM; // R3
					end
				end
			LIFE_RUN:
			begin
				if (link.cfgRd) // R11
				begin
					next_s.cfgRdata = rd;
					next_s.cfgRvalid = 1'b1;
				end
				if (link.cfgWr) // R11
				begin
					unique case (link.cfgAddr)
						OFF_PREFETCH:
						begin
							next_s.viEn = link.cfgWdata[VI_EN_BIT]; // R19
							if (link.cfgWdata[UPTC_LSB +: 3] != TC_ZERO)
								next_s.upTc = link.cfgWdata[UPTC_LSB +: 3]; // R20
						end
						OFF_LEGACY:
						begin
							next_s.legacy = link.cfgWdata[LEGACY_BIT];
							next_s.subDec = link.cfgWdata[SUBDEC_BIT];
						end
						OFF_BUSNUM:
						begin
							next_s.priBus = link.cfgWdata[7:0];
							next_s.secBus = link.cfgWdata[15:8];
							next_s.subBus = link.cfgWdata[23:16];
						end
						OFF_MEMWIN:
						begin
							next_s.memBase = link.cfgWdata[15:4];
							next_s.memLimit = link.cfgWdata[31:20];
						end
						OFF_PCIX:
							if (!s.legacy)
								next_s.pcixHi = link.cfgWdata[31:16]; // R9
						default: next_s.pcixHi = s.pcixHi;
					endcase
				end
				if (link.tlpValid)
				begin
					next_s.respValid = 1'b1;
					next_s.respFwd = fwd;
					next_s.respMal = bad;
					next_s.respRoute = route;
					next_s.respDest = link.tlpType[2:0]; // R16
					next_s.respHdr4 = link.tlpFmt[FMT_4DW_BIT]; // R13
					next_s.respData = hasData;
					next_s.dnFwd = fwd; // R12
					next_s.dnMal = bad;
				end
				if (pciCycValid && s.subDec && !(pciCycAddr[31:20] >= s.memBase
					&& pciCycAddr[31:20] <= s.memLimit))
					next_s.claim = 1'b1; // R10
			end
		endcase

		if (!perstN)
		begin
			next_s = DEV_INIT; // R19
			next_s.sync1 = {link.fundamentalResetN, link.modeSelectOne, reqStrapPins};
			next_s.sync2 = s.sync1;
		end
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= DEV_INIT;
		else
			s <= next_s;
	end
	assign link.cfgRdata      = s.cfgRdata;
	assign link.cfgRvalid     = s.cfgRvalid;
	assign link.respValid     = s.respValid;
	assign link.respFwd       = s.respFwd;
	assign link.respMalformed = s.respMal;
	assign link.respRoute     = s.respRoute;
	assign link.respMsgDest   = s.respDest;
	assign link.respHdr4dw    = s.respHdr4;
	assign link.respHasData   = s.respData;
	assign clkPmEnable    = s.clkPm;
	assign twoDeviceLimit = s.clkPm; // R3
	assign legacyMode     = s.legacy;
	assign viEnable       = s.viEn;
	assign upstreamTc     = s.upTc;
	assign dnForward      = s.dnFwd;
	assign dnMalformed    = s.dnMal;
	assign pciClaim       = s.claim;
endmodule

// >>> pxb_pkg.sv
package pxb_pkg;
	// device configuration offsets
	localparam logic [7:0] OFF_IDS      = 8'h00;
	localparam logic [7:0] OFF_CLASS    = 8'h08;
	localparam logic [7:0] OFF_BUSNUM   = 8'h18;
	localparam logic [7:0] OFF_MEMWIN   = 8'h20;
	localparam logic [7:0] OFF_CAPPTR   = 8'h34;
	localparam logic [7:0] OFF_PREFETCH = 8'h40;
	localparam logic [7:0] OFF_PCIX     = 8'h80;
	localparam logic [7:0] OFF_LEGACY   = 8'h98;
	localparam logic [7:0] OFF_PCIECAP  = 8'ha0;
	localparam logic [7:0] OFF_STRAPST  = 8'hc0;
	// fields
	localparam int VI_EN_BIT  = 26;
	localparam int UPTC_LSB   = 27;
	localparam int LEGACY_BIT = 0;
	localparam int SUBDEC_BIT = 1;
	localparam int FMT_4DW_BIT  = 0;
	localparam int FMT_DATA_BIT = 1;
	localparam logic [7:0] BASE_CLASS   = 8'h06;
	localparam logic [7:0] SUB_CLASS    = 8'h04;
	localparam logic [7:0] PROGIF_NOSUB = 8'h00;
	localparam logic [7:0] PROGIF_SUB   = 8'h01;
	localparam logic [7:0] CAP_ID_PCIX  = 8'h07;
	localparam logic [7:0] CAP_ID_PCIE  = 8'h10;
	localparam logic [3:0] CAP_VER      = 4'h1;
	localparam logic [2:0] TC_ZERO      = 3'h0;
	localparam logic [2:0] UPTC_RESET   = 3'h1;
	localparam logic [1:0] STRAP_CLKPM  = 2'h0;
	// packet types
	localparam logic [4:0] TYPE_MEM  = 5'h00;
	localparam logic [4:0] TYPE_IO   = 5'h02;
	localparam logic [4:0] TYPE_CFG0 = 5'h04;
	localparam logic [4:0] TYPE_CFG1 = 5'h05;
	localparam logic [1:0] MSG_GRP   = 2'h2;
	localparam logic [1:0] AS_GRP    = 2'h3;
	localparam int PAYLOAD_MAX_DW = 64;
	localparam int LEN_W = 10;
	typedef enum logic [1:0] {
		ROUTE_ADDR = 2'h0,
		ROUTE_ID   = 2'h1,
		ROUTE_IMPL = 2'h2,
		ROUTE_NONE = 2'h3
	} pxb_route_t;
	typedef enum logic [1:0] {
		LIFE_HELD = 2'h1,
		LIFE_RUN  = 2'h2
	} pxb_life_t;
	// host command port offsets
	localparam logic [7:0] H_CTRL    = 8'h00;
	localparam logic [7:0] H_CFGADDR = 8'h04;
	localparam logic [7:0] H_CFGDATA = 8'h08;
	localparam logic [7:0] H_CFGREAD = 8'h0c;
	localparam logic [7:0] H_TLPHDR  = 8'h10;
	localparam logic [7:0] H_TLPADDR = 8'h14;
	localparam logic [7:0] H_TLPBUS  = 8'h18;
	localparam logic [7:0] H_TLPSEND = 8'h1c;
	localparam logic [7:0] H_STATUS  = 8'h20;
endpackage

// >>> pxb_if.sv
`timescale 1ns/1ns
interface pxb_if;
	import pxb_pkg::*;
	logic             fundamentalResetN;
	logic             modeSelectZero;
	logic             modeSelectOne;
	logic             cfgWr;
	logic             cfgRd;
	logic [7:0]       cfgAddr;
	logic [31:0]      cfgWdata;
	logic [31:0]      cfgRdata;
	logic             cfgRvalid;
	logic             tlpValid;
	logic [1:0]       tlpFmt;
	logic [4:0]       tlpType;
	logic [2:0]       tlpTc;
	logic [LEN_W-1:0] tlpLen;
	logic [31:0]      tlpAddr;
	logic [7:0]       tlpBus;
	logic             respValid;
	logic             respFwd;
	logic             respMalformed;
	logic [1:0]       respRoute;
	logic [2:0]       respMsgDest;
	logic             respHdr4dw;
	logic             respHasData;
	modport dev (
		input  fundamentalResetN, modeSelectZero, modeSelectOne,
		input  cfgWr, cfgRd, cfgAddr, cfgWdata,
		output cfgRdata, cfgRvalid,
		input  tlpValid, tlpFmt, tlpType, tlpTc, tlpLen, tlpAddr, tlpBus,
		output respValid, respFwd, respMalformed, respRoute, respMsgDest,
		output respHdr4dw, respHasData
	);
	modport host (
		output fundamentalResetN, modeSelectZero, modeSelectOne,
		output cfgWr, cfgRd, cfgAddr, cfgWdata,
		input  cfgRdata, cfgRvalid,
		output tlpValid, tlpFmt, tlpType, tlpTc, tlpLen, tlpAddr, tlpBus,
		input  respValid, respFwd, respMalformed, respRoute, respMsgDest,
		input  respHdr4dw, respHasData
	);
endinterface

// >>> pxb_host_end.sv
`timescale 1ns/1ns
module pxb_host_end
	import pxb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	pxb_if.host              link,
	input  wire logic [7:0]  cmdAddr,
	input  wire logic [31:0] cmdWdata,
	input  wire logic        cmdWr,
	input  wire logic        cmdRd,
	output logic [31:0]      cmdRdata
);
	typedef struct packed {
		logic             runEnable;
		logic [7:0]       cfgAddr;
		logic [31:0]      cfgWdata;
		logic [31:0]      cfgLast;
		logic             cfgWr;
		logic             cfgRd;
		logic [1:0]       fmt;
		logic [4:0]       tlpType;
		logic [2:0]       tc;
		logic [LEN_W-1:0] len;
		logic [31:0]      tlpAddr;
		logic [7:0]       tlpBus;
		logic             tlpValid;
		logic [9:0]       resp;
		logic             respDone;
		logic             cfgDone;
		logic [31:0]      rdata;
	} pxb_host_state_t;

	pxb_host_state_t s;
	pxb_host_state_t next_s;

	always_comb
	begin
		next_s = s;
		next_s.cfgWr = 1'b0;
		next_s.cfgRd = 1'b0;
		next_s.tlpValid = 1'b0;
		if (cmdRd)
		begin
			unique case (cmdAddr)
				H_CTRL:
					next_s.rdata = {31'h0, s.runEnable};
				H_CFGADDR:
					next_s.rdata = {24'h0, s.cfgAddr};
				H_CFGDATA:
					next_s.rdata = s.cfgLast;
				H_TLPHDR:
					next_s.rdata = {12'h0, s.len, s.tc, s.tlpType, s.fmt};
				H_TLPADDR:
					next_s.rdata = s.tlpAddr;
				H_TLPBUS:
					next_s.rdata = {24'h0, s.tlpBus};
				H_STATUS:
				begin
					next_s.rdata = {20'h0, s.resp, s.cfgDone, s.respDone};
					next_s.respDone = 1'b0;
					next_s.cfgDone = 1'b0;
				end
				default:
					next_s.rdata = '0;
			endcase
		end
		if (cmdWr)
		begin
			unique case (cmdAddr)
				H_CTRL:
					next_s.runEnable = cmdWdata[0];
				H_CFGADDR:
					next_s.cfgAddr = cmdWdata[7:0];
				H_CFGDATA:
				begin
					next_s.cfgWdata = cmdWdata;
					next_s.cfgWr = 1'b1; // R11
				end
				H_CFGREAD:
					next_s.cfgRd = 1'b1; // R11
				H_TLPHDR:
				begin
					next_s.fmt = cmdWdata[1:0];
					next_s.tlpType = cmdWdata[6:2];
					next_s.tc = cmdWdata[9:7];
					next_s.len = cmdWdata[19:10];
				end
				H_TLPADDR:
					next_s.tlpAddr = cmdWdata;
				H_TLPBUS:
					next_s.tlpBus = cmdWdata[7:0];
				H_TLPSEND:
				begin
					next_s.tlpValid = 1'b1; // R12
					if (s.tlpType[4:3] == MSG_GRP)
						next_s.tc = TC_ZERO; // R17
				end
				default:
					next_s.runEnable = s.runEnable;
			endcase
		end
		if (link.cfgRvalid)
		begin
			next_s.cfgLast = link.cfgRdata;
			next_s.cfgDone = 1'b1;
		end
		if (link.respValid)
		begin
			next_s.resp = {link.respMsgDest, link.respRoute, link.respHdr4dw,
				link.respHasData, link.respMalformed, link.respFwd, 1'b1};
			next_s.respDone = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign link.fundamentalResetN = s.runEnable;
	assign link.modeSelectZero    = 1'b0; // R1
	assign link.modeSelectOne     = 1'b0; // R1
	assign link.cfgWr    = s.cfgWr;
	assign link.cfgRd    = s.cfgRd;
	assign link.cfgAddr  = s.cfgAddr;
	assign link.cfgWdata = s.cfgWdata;
	assign link.tlpValid = s.tlpValid;
	assign link.tlpFmt   = s.fmt;
	assign link.tlpType  = s.tlpType;
	assign link.tlpTc    = s.tc; // R17
	assign link.tlpLen   = s.len;
	assign link.tlpAddr  = s.tlpAddr;
	assign link.tlpBus   = s.tlpBus;
	assign cmdRdata = s.rdata;
endmodule

// >>> pxb_checker.sv
`timescale 1ns/1ns
module pxb_checker
	import pxb_pkg::*;
(
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             fundamentalResetN,
	input wire logic             modeSelectZero,
	input wire logic             modeSelectOne,
	input wire logic             cfgRd,
	input wire logic             cfgRvalid,
	input wire logic             tlpValid,
	input wire logic [1:0]       tlpFmt,
	input wire logic [4:0]       tlpType,
	input wire logic [2:0]       tlpTc,
	input wire logic [LEN_W-1:0] tlpLen,
	input wire logic             respValid,
	input wire logic             respFwd,
	input wire logic             respMalformed,
	input wire logic [1:0]       respRoute,
	input wire logic [2:0]       respMsgDest,
	input wire logic             respHdr4dw,
	input wire logic             respHasData
);
	logic [2:0] hiCnt;
	logic       runOk;
	// cycles since fundamental reset went high
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hiCnt <= 3'h0;
		else if (!fundamentalResetN)
			hiCnt <= 3'h0;
		else if (hiCnt != 3'h7)
			hiCnt <= hiCnt + 3'h1;
	end
	assign runOk = (hiCnt == 3'h7);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_tlp;
		tlpValid && runOk;
	endsequence
	sequence s_msg;
		tlpValid && runOk && tlpType[4:3] == MSG_GRP;
	endsequence
	property p_mode;
		!modeSelectZero && !modeSelectOne;
	endproperty
	a_mode: assert property (p_mode) else $error("mode select not low");
	property p_cfg_ans;
		cfgRd && runOk |=> cfgRvalid;
	endproperty
	a_cfg_ans: assert property (p_cfg_ans) else $error("no config answer");
	property p_cfg_cause;
		cfgRvalid |-> $past(cfgRd);
	endproperty
	a_cfg_cause: assert property (p_cfg_cause) else $error("spurious config answer");
	property p_fmt;
		s_tlp |=> respValid && respHdr4dw == $past(tlpFmt[0]) && respHasData == $past(tlpFmt[1]);
	endproperty
	a_fmt: assert property (p_fmt) else $error("format decode wrong");
	property p_len;
		s_tlp ##0 (tlpFmt[1] && (tlpLen == 0 || tlpLen > PAYLOAD_MAX_DW)) |=> respMalformed;
	endproperty
	a_len: assert property (p_len) else $error("bad payload accepted");
	property p_msg;
		s_msg |=> respRoute == ROUTE_IMPL && respMsgDest == $past(tlpType[2:0]);
	endproperty
	a_msg: assert property (p_msg) else $error("message routing wrong");
	property p_msg_tc;
		s_msg |-> tlpTc == TC_ZERO;
	endproperty
	a_msg_tc: assert property (p_msg_tc) else $error("message class not zero");
	property p_as;
		s_tlp ##0 tlpType[4:3] == AS_GRP |=> respMalformed && !respFwd;
	endproperty
	a_as: assert property (p_as) else $error("switching message accepted");
	property p_tc;
		s_tlp ##0 (tlpType != TYPE_MEM && tlpTc != TC_ZERO) |=> respMalformed && !respFwd;
	endproperty
	a_tc: assert property (p_tc) else $error("nonzero class accepted");
	property p_mem;
		s_tlp ##0 (tlpType == TYPE_MEM && !tlpFmt[1]) |=> !respMalformed;
	endproperty
	a_mem: assert property (p_mem) else $error("memory packet refused");
endmodule

// >>> pcie_to_pci_bridge_decode_test.sv
`timescale 1ns/1ns
module pcie_to_pci_bridge_decode_test
	import pxb_pkg::*;
;
	logic        clk, rst, pciCycValid, cmdWr, cmdRd;
	logic [1:0]  reqStrapPins;
	logic [31:0] pciCycAddr, cmdWdata, cmdRdata, d;
	logic [7:0]  cmdAddr;
	logic        clkPmEnable, twoDeviceLimit, legacyMode, viEnable;
	logic        dnForward, dnMalformed, pciClaim;
	logic [2:0]  upstreamTc;
	int          error_cnt, cmp_count;
	int          fwdCnt, malCnt;
	pxb_if u_pxb_if ();
	pxb_bridge_dev u_pxb_bridge_dev (.clk(clk), .rst(rst), .link(u_pxb_if.dev),
		.reqStrapPins(reqStrapPins), .pciCycValid(pciCycValid), .pciCycAddr(pciCycAddr),
		.clkPmEnable(clkPmEnable), .twoDeviceLimit(twoDeviceLimit), .legacyMode(legacyMode),
		.viEnable(viEnable), .upstreamTc(upstreamTc), .dnForward(dnForward),
		.dnMalformed(dnMalformed), .pciClaim(pciClaim));
	pxb_host_end u_pxb_host_end (.clk(clk), .rst(rst), .link(u_pxb_if.host),
		.cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd),
		.cmdRdata(cmdRdata));
	pxb_checker u_pxb_checker (.clk(clk), .rst(rst),
		.fundamentalResetN(u_pxb_if.fundamentalResetN), .modeSelectZero(u_pxb_if.modeSelectZero),
		.modeSelectOne(u_pxb_if.modeSelectOne), .cfgRd(u_pxb_if.cfgRd),
		.cfgRvalid(u_pxb_if.cfgRvalid), .tlpValid(u_pxb_if.tlpValid), .tlpFmt(u_pxb_if.tlpFmt),
		.tlpType(u_pxb_if.tlpType), .tlpTc(u_pxb_if.tlpTc), .tlpLen(u_pxb_if.tlpLen),
		.respValid(u_pxb_if.respValid), .respFwd(u_pxb_if.respFwd),
		.respMalformed(u_pxb_if.respMalformed), .respRoute(u_pxb_if.respRoute),
		.respMsgDest(u_pxb_if.respMsgDest), .respHdr4dw(u_pxb_if.respHdr4dw),
		.respHasData(u_pxb_if.respHasData));
	always #25 clk = ~clk;
	// counts downstream forward and malformed pulses
	always @(posedge clk)
	begin
		if (dnForward)
			fwdCnt <= fwdCnt + 1;
		if (dnMalformed)
			malCnt <= malCnt + 1;
	end
	task automatic results();
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		cmdWr <= 1'b1;
		cmdAddr <= a;
		cmdWdata <= v;
		@(posedge clk);
		cmdWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		cmdRd <= 1'b1;
		cmdAddr <= a;
		@(posedge clk);
		cmdRd <= 1'b0;
		#1 v = cmdRdata;
	endtask
	// status polling, bounded
	task automatic poll(input logic [31:0] m, output logic [31:0] s);
		s = 32'h0;
		for (int i = 0; i < 20 && (s & m) === 32'h0; i++)
			rd(H_STATUS, s);
		if ((s & m) === 32'h0)
		begin
			error_cnt++;
			$display("BAD %0t status never set", $time);
		end
	endtask
	task automatic cfg_wr(input logic [7:0] a, input logic [31:0] v);
		wr(H_CFGADDR, {24'h0, a});
		wr(H_CFGDATA, v);
		repeat (2) @(posedge clk);
	endtask
	task automatic cfg_rd(input logic [7:0] a, output logic [31:0] v);
		logic [31:0] s;
		wr(H_CFGADDR, {24'h0, a});
		wr(H_CFGREAD, 32'h0);
		poll(32'h2, s);
		rd(H_CFGDATA, v);
	endtask
	task automatic tlp(input logic [1:0] f, input logic [4:0] t, input logic [2:0] c,
		input logic [9:0] n, input logic [31:0] a, input logic [7:0] b, input logic m,
		input logic w, input logic [1:0] r);
		logic [31:0] s;
		int          f0;
		int          m0;
		f0 = fwdCnt;
		m0 = malCnt;
		wr(H_TLPHDR, {12'h0, n, c, t, f});
		wr(H_TLPADDR, a);
		wr(H_TLPBUS, {24'h0, b});
		wr(H_TLPSEND, 32'h0);
		poll(32'h1, s);
		chk({28'h0, s[6:3]}, {28'h0, f[0], f[1], m, w});
		chk(fwdCnt - f0 + 2 * (malCnt - m0), {30'h0, m, w});
		if (!m)
			chk({27'h0, s[11:7]}, {27'h0, t[2:0], r});
	endtask
	task automatic pci(input logic [31:0] a, input logic e);
		@(posedge clk);
		pciCycValid <= 1'b1;
		pciCycAddr <= a;
		@(posedge clk);
		pciCycValid <= 1'b0;
		#1 chk({31'h0, pciClaim}, {31'h0, e});
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		results();
	end
	initial
	begin
		{clk, pciCycValid, cmdWr, cmdRd, reqStrapPins} = '0;
		{pciCycAddr, cmdWdata, cmdAddr} = '0;
		error_cnt = 0;
		cmp_count = 0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1 chk({28'h0, clkPmEnable, viEnable, upstreamTc[1:0]}, 32'h1);
		wr(H_CTRL, 32'h1);
		repeat (10) @(posedge clk);
		chk({30'h0, clkPmEnable, twoDeviceLimit}, 32'h3);
		cfg_rd(OFF_STRAPST, d);
		chk(d & 32'h7, 32'h4);
		reqStrapPins <= 2'h3;
		repeat (6) @(posedge clk);
		chk({31'h0, clkPmEnable}, 32'h1);
		wr(H_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		wr(H_CTRL, 32'h1);
		repeat (10) @(posedge clk);
		chk({30'h0, clkPmEnable, twoDeviceLimit}, 32'h0);
		cfg_rd(OFF_STRAPST, d);
		chk(d & 32'h7, 32'h3);
		rd(8'h3c, d);
		chk(d, 32'h0);
		cfg_rd(8'h50, d);
		chk(d, 32'h0);
		cfg_rd(OFF_CLASS, d);
		chk(d & 32'hffffff00, 32'h06040000);
		cfg_rd(OFF_CAPPTR, d);
		chk(d & 32'hff, 32'h80);
		cfg_rd(OFF_PCIX, d);
		chk(d & 32'hff, {24'h0, CAP_ID_PCIX});
		cfg_rd(OFF_PCIECAP, d);
		chk(d & 32'h000f00ff, {12'h0, CAP_VER, 8'h0, CAP_ID_PCIE});
		cfg_rd(OFF_PREFETCH, d);
		chk(d & 32'h04000000, 32'h0);
		cfg_wr(OFF_PREFETCH, 32'h2c000000);
		chk({28'h0, viEnable, upstreamTc}, 32'hd);
		cfg_wr(OFF_PREFETCH, 32'h04000000);
		chk({29'h0, upstreamTc}, 32'h5);
		cfg_wr(OFF_MEMWIN, 32'h1ff01000);
		cfg_wr(OFF_BUSNUM, 32'h00040100);
		tlp(2'h0, TYPE_MEM, 3'h3, 10'd1, 32'h10000000, 8'h0, 1'b0, 1'b1, ROUTE_ADDR);
		tlp(2'h3, TYPE_MEM, 3'h0, 10'd64, 32'h10000000, 8'h0, 1'b0, 1'b1, ROUTE_ADDR);
		tlp(2'h2, TYPE_MEM, 3'h0, 10'd65, 32'h10000000, 8'h0, 1'b1, 1'b0, ROUTE_ADDR);
		tlp(2'h2, TYPE_MEM, 3'h0, 10'd0, 32'h10000000, 8'h0, 1'b1, 1'b0, ROUTE_ADDR);
		tlp(2'h2, TYPE_IO, 3'h1, 10'd1, 32'h100, 8'h0, 1'b1, 1'b0, ROUTE_ADDR);
		tlp(2'h0, TYPE_IO, 3'h0, 10'd1, 32'h100, 8'h0, 1'b0, 1'b0, ROUTE_ADDR);
		tlp(2'h0, TYPE_CFG1, 3'h0, 10'd1, 32'h0, 8'h3, 1'b0, 1'b1, ROUTE_ID);
		tlp(2'h0, TYPE_CFG1, 3'h0, 10'd1, 32'h0, 8'h9, 1'b0, 1'b0, ROUTE_ID);
		tlp(2'h0, TYPE_CFG1, 3'h2, 10'd1, 32'h0, 8'h3, 1'b1, 1'b0, ROUTE_ID);
		tlp(2'h0, TYPE_CFG0, 3'h0, 10'd1, 32'h0, 8'h0, 1'b0, 1'b0, ROUTE_ID);
		tlp(2'h1, 5'h14, 3'h5, 10'd0, 32'h0, 8'h0, 1'b0, 1'b0, ROUTE_IMPL);
		tlp(2'h1, 5'h13, 3'h0, 10'd0, 32'h0, 8'h0, 1'b0, 1'b0, ROUTE_IMPL);
		tlp(2'h1, 5'h18, 3'h0, 10'd0, 32'h0, 8'h0, 1'b1, 1'b0, ROUTE_NONE);
		pci(32'h80000000, 1'b0);
		cfg_wr(OFF_LEGACY, 32'h2);
		pci(32'h80000000, 1'b1);
		pci(32'h10000000, 1'b0);
		cfg_wr(OFF_LEGACY, 32'h1);
		chk({31'h0, legacyMode}, 32'h1);
		cfg_rd(OFF_CLASS, d);
		chk(d & 32'hffffff00, 32'h06040100);
		cfg_wr(OFF_PCIX, 32'hffffffff);
		cfg_rd(OFF_PCIX, d);
		chk(d, 32'h0);
		cfg_rd(OFF_PCIECAP, d);
		chk(d, 32'h0);
		cfg_rd(OFF_CAPPTR, d);
		chk(d, 32'h0);
		tlp(2'h2, TYPE_MEM, 3'h0, 10'd4, 32'h80000000, 8'h0, 1'b0, 1'b1, ROUTE_ADDR);
		tlp(2'h0, TYPE_IO, 3'h0, 10'd1, 32'h100, 8'h0, 1'b0, 1'b1, ROUTE_ADDR);
		tlp(2'h0, TYPE_CFG1, 3'h0, 10'd1, 32'h0, 8'h9, 1'b0, 1'b0, ROUTE_ID);
		results();
	end
endmodule
